// [common/ifcr_pkg.sv]
// constants for the interrupt flag and control register block
package ifcr_pkg;
  // register indices on the plain register port (word addresses)
  localparam logic [3:0] IFCR_ADDR_CTRL_ONE  = 4'h0;
  localparam logic [3:0] IFCR_ADDR_CTRL_TWO  = 4'h1;
  localparam logic [3:0] IFCR_ADDR_FLAGS_ZERO = 4'h2;
  localparam logic [3:0] IFCR_ADDR_FLAGS_ONE = 4'h3;
  localparam logic [3:0] IFCR_ADDR_ENABLE_ZERO = 4'h4;
  localparam logic [3:0] IFCR_ADDR_ENABLE_ONE = 4'h5;
  localparam int         IFCR_ADDR_W        = 4;
  localparam int         IFCR_DATA_W        = 16;
  // control register one field positions
  localparam int IFCR_STACK_FAULT_BIT = 2;
  localparam int IFCR_OSC_FAULT_BIT   = 1;
  // control register two field positions and the external pin count
  localparam int IFCR_ALT_VECTOR_BIT  = 15;
  localparam int IFCR_DISABLE_BIT     = 14;
  localparam int IFCR_EXT_COUNT       = 3;
  // implemented-bit masks of the flag registers
  localparam logic [15:0] IFCR_FLAGS_ZERO_MASK = 16'h7fef;
  localparam logic [15:0] IFCR_FLAGS_ONE_MASK  = 16'he87f;
  // positions of the external request flags
  localparam int IFCR_EXT0_FLAG_BIT = 0;
  localparam int IFCR_EXT1_FLAG_BIT = 0;
  localparam int IFCR_EXT2_FLAG_BIT = 1;
  // reset value of every register
  localparam logic [15:0] IFCR_RESET_VALUE = 16'h0000;
endpackage

// [src/ifcr_regs.sv]
// interrupt flag, trap status and control register block
`timescale 1ns/1ns
//
// Contract
// R1: stack fault trap sets bit two
// R2: oscillator fault trap sets bit one
// R3: control one bit zero reads zero
// R4: bit fifteen selects alternate vector table
// R5: bit fourteen mirrors disable, read only
// R6: control two bits 13..3 read zero
// R7: polarity bits: one falling, zero rising
// R8: flags zero upper byte source layout
// R9: flags zero lower byte source layout
// R10: flags one comparators and change notification
// R11: flags one pulse gens, match, externals
// R12: flags latch events, software read/write
// R13: all implemented bits reset to zero
// R14: request needs flag and enable both
// R15: external inputs edge sensitive only
// R16: alternate selection covers traps too
// R17: pins synchronised; set beats clear
module ifcr_regs (
  // clock, reset, enable
  input  wire logic                             clk_sys_i,
  input  wire logic                             rstn_i,
  input  wire logic                             clk_en_i,
  // register port
  input  wire logic [ifcr_pkg::IFCR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [ifcr_pkg::IFCR_DATA_W-1:0] reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic      [ifcr_pkg::IFCR_DATA_W-1:0] reg_rdata_o,
  // trap and core status events
  input  wire logic                             stack_fault_i,
  input  wire logic                             osc_fault_i,
  input  wire logic                             irq_disable_active_i,
  // peripheral event pulses, laid out as the flag registers
  input  wire logic [15:0]                      periph_events_zero_i,
  input  wire logic [15:0]                      periph_events_one_i,
  // external interrupt pins
  input  wire logic [ifcr_pkg::IFCR_EXT_COUNT-1:0] ext_pin_i,
  // towards the core priority logic
  output logic      [15:0]                      pending_zero_o,
  output logic      [15:0]                      pending_one_o,
  output logic                                  alt_vector_select_o
);
  import ifcr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic        stack_fault_status, next_stack_fault_status;   // trap status
  logic        osc_fault_status, next_osc_fault_status;       // trap status
  logic        alt_vector_select, next_alt_vector_select;     // vector table choice
  logic [2:0]  ext_edge_polarity, next_ext_edge_polarity;     // one per pin
  logic [15:0] flags_zero, next_flags_zero;                   // request flags
  logic [15:0] flags_one, next_flags_one;                     // request flags
  logic [15:0] enable_zero, next_enable_zero;                 // enable regs
  logic [15:0] enable_one, next_enable_one;                   // enable regs
  logic [2:0]  sync_meta, sync_pin, pin_prev;                 // pin synchroniser
  logic [2:0]  sync_fill;                                     // primes after reset
  logic [2:0]  ext_edge;                                      // detected edges
  logic [15:0] next_rdata;                                    // read data
  logic        wr_ctrl_one, wr_ctrl_two, wr_fz, wr_fo;        // write decodes
  logic [15:0] ctrl_one_view, ctrl_two_view;                  // read views
  logic [15:0] set_zero, set_one;                             // hardware sets

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: first stage feeds only the second
  // a fill marker gates edge detection until the chain holds real samples,
  // so a pin held high across reset cannot pass for a fresh edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_meta <= 3'h0;
      sync_pin  <= 3'h0;
      pin_prev  <= 3'h0;
      sync_fill <= 3'h0;                                      // chain not primed
    end else if (clk_en_i) begin
      sync_meta <= ext_pin_i;                                 // [R17]
      sync_pin  <= sync_meta;
      pin_prev  <= sync_pin;
      sync_fill <= {sync_fill[1:0], 1'b1};                    // [R15]
    end
  end

  // edge detect per pin; a static level never fires
  genvar gi;
  generate
    for (gi = 0; gi < IFCR_EXT_COUNT; gi++) begin : g_edge
      // polarity one picks falling, zero picks rising
      // limitation: an edge in the first enabled cycle after reset is lost
      assign ext_edge[gi] = sync_fill[2] & (ext_edge_polarity[gi] ?
                            (pin_prev[gi] & ~sync_pin[gi]) :    // [R7] [R15]
                            (~pin_prev[gi] & sync_pin[gi]));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read views of the control registers
  always_comb begin
    ctrl_one_view = 16'h0000;                                 // [R3]
    ctrl_one_view[IFCR_STACK_FAULT_BIT] = stack_fault_status;
    ctrl_one_view[IFCR_OSC_FAULT_BIT]   = osc_fault_status;
    ctrl_two_view = 16'h0000;                                 // [R6]
    ctrl_two_view[IFCR_ALT_VECTOR_BIT] = alt_vector_select;
    ctrl_two_view[IFCR_DISABLE_BIT]    = irq_disable_active_i; // [R5]
    ctrl_two_view[2:0]                 = ext_edge_polarity;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next-state for all registers but the pin synchroniser
  always_comb begin
    wr_ctrl_one = reg_wr_i && (reg_addr_i == IFCR_ADDR_CTRL_ONE);
    wr_ctrl_two = reg_wr_i && (reg_addr_i == IFCR_ADDR_CTRL_TWO);
    wr_fz       = reg_wr_i && (reg_addr_i == IFCR_ADDR_FLAGS_ZERO);
    wr_fo       = reg_wr_i && (reg_addr_i == IFCR_ADDR_FLAGS_ONE);
    // hardware sets: peripheral pulses plus pin edges
    set_zero = periph_events_zero_i;                          // [R8] [R9]
    set_zero[IFCR_EXT0_FLAG_BIT] = periph_events_zero_i[IFCR_EXT0_FLAG_BIT] | ext_edge[0];
    set_one  = periph_events_one_i;                           // [R10] [R11]
    set_one[IFCR_EXT1_FLAG_BIT] = periph_events_one_i[IFCR_EXT1_FLAG_BIT] | ext_edge[1];
    set_one[IFCR_EXT2_FLAG_BIT] = periph_events_one_i[IFCR_EXT2_FLAG_BIT] | ext_edge[2];
    // trap status: sticky, software may clear, set wins
    next_stack_fault_status = stack_fault_status;
    next_osc_fault_status   = osc_fault_status;
    if (wr_ctrl_one) begin
      next_stack_fault_status = reg_wdata_i[IFCR_STACK_FAULT_BIT];
      next_osc_fault_status   = reg_wdata_i[IFCR_OSC_FAULT_BIT];
    end
    if (stack_fault_i) begin
      next_stack_fault_status = 1'b1;                         // [R1] [R17]
    end
    if (osc_fault_i) begin
      next_osc_fault_status = 1'b1;                           // [R2] [R17]
    end
    // control two: disable bit is never stored
    next_alt_vector_select = alt_vector_select;
    next_ext_edge_polarity = ext_edge_polarity;
    if (wr_ctrl_two) begin
      next_alt_vector_select = reg_wdata_i[IFCR_ALT_VECTOR_BIT]; // [R4]
      next_ext_edge_polarity = reg_wdata_i[2:0];              // [R7]
    end
    // flags: write stores, hardware set ORed after so it wins
    next_flags_zero = wr_fz ? reg_wdata_i : flags_zero;       // [R12]
    next_flags_zero = (next_flags_zero | set_zero) & IFCR_FLAGS_ZERO_MASK; // [R17]
    next_flags_one  = wr_fo ? reg_wdata_i : flags_one;
    next_flags_one  = (next_flags_one | set_one) & IFCR_FLAGS_ONE_MASK;
    // enable registers share the flag layout
    next_enable_zero = enable_zero;
    next_enable_one  = enable_one;
    if (reg_wr_i && (reg_addr_i == IFCR_ADDR_ENABLE_ZERO)) begin
      next_enable_zero = reg_wdata_i & IFCR_FLAGS_ZERO_MASK;
    end
    if (reg_wr_i && (reg_addr_i == IFCR_ADDR_ENABLE_ONE)) begin
      next_enable_one = reg_wdata_i & IFCR_FLAGS_ONE_MASK;
    end
    // read mux; unmapped reads return zero
    next_rdata = 16'h0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        IFCR_ADDR_CTRL_ONE:    next_rdata = ctrl_one_view;
        IFCR_ADDR_CTRL_TWO:    next_rdata = ctrl_two_view;
        IFCR_ADDR_FLAGS_ZERO:  next_rdata = flags_zero;
        IFCR_ADDR_FLAGS_ONE:   next_rdata = flags_one;
        IFCR_ADDR_ENABLE_ZERO: next_rdata = enable_zero;
        IFCR_ADDR_ENABLE_ONE:  next_rdata = enable_one;
        default:               next_rdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register everything but the pin synchroniser; clock enable freezes state
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_fault_status <= 1'b0;                             // [R13]
      osc_fault_status   <= 1'b0;
      alt_vector_select  <= 1'b0;
      ext_edge_polarity  <= 3'h0;
      flags_zero         <= IFCR_RESET_VALUE;
      flags_one          <= IFCR_RESET_VALUE;
      enable_zero        <= IFCR_RESET_VALUE;
      enable_one         <= IFCR_RESET_VALUE;
      reg_rdata_o        <= IFCR_RESET_VALUE;
    end else if (clk_en_i) begin
      stack_fault_status <= next_stack_fault_status;
      osc_fault_status   <= next_osc_fault_status;
      alt_vector_select  <= next_alt_vector_select;
      ext_edge_polarity  <= next_ext_edge_polarity;
      flags_zero         <= next_flags_zero;
      flags_one          <= next_flags_one;
      enable_zero        <= next_enable_zero;
      enable_one         <= next_enable_one;
      reg_rdata_o        <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs to the core; selection applies to traps as well
  assign pending_zero_o      = flags_zero & enable_zero;      // [R14]
  assign pending_one_o       = flags_one & enable_one;
  assign alt_vector_select_o = alt_vector_select;             // [R16]

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  // trap steps: the event is seen on an enabled edge, the status shows next
  sequence s_fault_seen;
    clk_en_i && stack_fault_i;
  endsequence
  sequence s_fault_held;
    ##1 (ctrl_one_view[IFCR_STACK_FAULT_BIT] == 1'b1);
  endsequence
  // pin steps: the synchroniser runs on two enabled edges in a row
  sequence s_sync_run;
    rstn_i && clk_en_i ##1 clk_en_i;
  endsequence
  // reset steps: reset seen low on two edges in a row
  sequence s_reset_held;
    !rstn_i ##1 !rstn_i;
  endsequence

  // stack fault event latches the status bit
  a_stack_fault_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R1]
    s_fault_seen |-> s_fault_held) else $error("stack fault not latched");

  // a software clear with no event leaves the bit at zero
  a_stack_fault_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R1]
    clk_en_i && wr_ctrl_one && !reg_wdata_i[IFCR_STACK_FAULT_BIT] && !stack_fault_i
    |=> !stack_fault_status)
    else $error("stack fault status not cleared");

  // oscillator fault event latches its status bit
  a_osc_fault_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
    clk_en_i && osc_fault_i |=> osc_fault_status) else $error("osc fault not latched");

  // the same clear behaviour for the oscillator status
  a_osc_fault_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R2]
    clk_en_i && wr_ctrl_one && !reg_wdata_i[IFCR_OSC_FAULT_BIT] && !osc_fault_i
    |=> !osc_fault_status)
    else $error("osc fault status not cleared");

  // control one bit zero and control two bits 13..3 never read back as one
  a_unused_bits_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R3]
    ctrl_one_view[0] == 1'b0 && ctrl_two_view[13:3] == 11'h000)
    else $error("unimplemented control bit set");

  // a read of control two carries the live disable level
  a_disable_mirror: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R5]
    clk_en_i && reg_rd_i && reg_addr_i == IFCR_ADDR_CTRL_TWO
    |=> reg_rdata_o[IFCR_DISABLE_BIT] == $past(irq_disable_active_i))
    else $error("disable status not mirrored");

  // a write to control two lands in the vector select
  a_alt_vector_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R4]
    clk_en_i && wr_ctrl_two |=> alt_vector_select_o == $past(reg_wdata_i[IFCR_ALT_VECTOR_BIT]))
    else $error("alternate vector select not written");

  // without a write the vector select keeps its value
  a_alt_vector_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R16]
    !(clk_en_i && wr_ctrl_two) |=> $stable(alt_vector_select_o))
    else $error("vector select moved without a write");

  // unimplemented flag positions stay clear whatever is written
  a_flag_masks: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R8]
    (flags_zero & ~IFCR_FLAGS_ZERO_MASK) == 16'h0000
    && (flags_one & ~IFCR_FLAGS_ONE_MASK) == 16'h0000)
    else $error("unimplemented flag bit set");

  // a software write to flags zero keeps every flag that a peripheral sets in that cycle
  a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R17]
    clk_en_i && wr_fz
    |=> (flags_zero & $past(periph_events_zero_i) & IFCR_FLAGS_ZERO_MASK)
        == ($past(periph_events_zero_i) & IFCR_FLAGS_ZERO_MASK))
    else $error("hardware set lost against clear");

  // a flags one write stores the data, merged with same-cycle sets
  a_flag_write_store: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R12]
    clk_en_i && wr_fo
    |=> flags_one == (($past(reg_wdata_i) | $past(set_one)) & IFCR_FLAGS_ONE_MASK))
    else $error("flag write not stored");

  // rising edge on pin zero under rising polarity
  a_rising_edge_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R15]
    clk_en_i && sync_fill[2] && !ext_edge_polarity[0] && !pin_prev[0] && sync_pin[0]
    |=> flags_zero[IFCR_EXT0_FLAG_BIT])
    else $error("rising edge on pin zero missed");

  // falling edge on pin one under falling polarity
  a_falling_edge_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R7]
    clk_en_i && sync_fill[2] && ext_edge_polarity[1] && pin_prev[1] && !sync_pin[1]
    |=> flags_one[IFCR_EXT1_FLAG_BIT])
    else $error("falling edge on pin one missed");

  // a pin whose level does not move never fires its detector
  a_static_no_edge: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R15]
    (ext_edge & ~(pin_prev ^ sync_pin)) == 3'h0)
    else $error("edge reported on a steady pin");

  // the synchronised pin is the raw pin two enabled edges back
  a_sync_two_stage: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R17]
    s_sync_run |=> sync_pin == $past(ext_pin_i, 2))
    else $error("pin synchroniser depth wrong");

  // a new enable word gates the flags of register one at once
  a_pending_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R14]
    clk_en_i && reg_wr_i && reg_addr_i == IFCR_ADDR_ENABLE_ONE
    |=> pending_one_o == (flags_one & $past(reg_wdata_i) & IFCR_FLAGS_ONE_MASK))
    else $error("pending request without enable");

  // the same gating for register zero
  a_pending_zero_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R14]
    clk_en_i && reg_wr_i && reg_addr_i == IFCR_ADDR_ENABLE_ZERO
    |=> pending_zero_o == (flags_zero & $past(reg_wdata_i) & IFCR_FLAGS_ZERO_MASK))
    else $error("pending zero request without enable");

  // every implemented bit except the pin polarities is zero while reset is held
  a_reset_values: assert property (@(posedge clk_sys_i) // [R13]
    s_reset_held |-> flags_zero == IFCR_RESET_VALUE && flags_one == IFCR_RESET_VALUE
    && enable_zero == IFCR_RESET_VALUE && enable_one == IFCR_RESET_VALUE
    && !stack_fault_status && !osc_fault_status && !alt_vector_select)
    else $error("register not cleared by reset");
endmodule

// [tb/ifcr_partner.sv]
// model of the peripheral event sources, trap sources and core status
`timescale 1ns/1ns
module ifcr_partner (
  // clock
  input  wire logic        clk_sys_i,
  // towards the flag block
  output logic      [15:0] ev_zero_o,
  output logic      [15:0] ev_one_o,
  output logic             stack_o,
  output logic             osc_o,
  output logic             disable_o,
  output logic      [2:0]  pin_o
);
  // every source idle at time zero
  initial begin
    ev_zero_o = 16'h0000;
    ev_one_o  = 16'h0000;
    stack_o   = 1'b0;
    osc_o     = 1'b0;
    disable_o = 1'b0;
    pin_o     = 3'h0;
  end
  // one-cycle pulse; peripherals never hold a request longer than that
  task automatic pulse(input logic [15:0] z, input logic [15:0] o, input logic s, input logic f);
    @(posedge clk_sys_i);
    ev_zero_o <= z;
    ev_one_o  <= o;
    stack_o   <= s;
    osc_o     <= f;
    @(posedge clk_sys_i);
    ev_zero_o <= 16'h0000;
    ev_one_o  <= 16'h0000;
    stack_o   <= 1'b0;
    osc_o     <= 1'b0;
  endtask
  // core disable level and pin levels, changed right after an edge
  task automatic level(input logic d, input logic [2:0] p);
    @(posedge clk_sys_i);
    disable_o <= d;
    pin_o     <= p;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the flag and control register block
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import ifcr_pkg::*;
  logic        clk_sys_i, rstn_i, clk_en_i, reg_wr_i, reg_rd_i, stk, osc, dis, alt;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, ev_z, ev_o, pend_z, pend_o;
  logic [2:0]  pins;
  int          err_total;
  int          checks_done;
  ifcr_regs i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .stack_fault_i(stk), .osc_fault_i(osc),
    .irq_disable_active_i(dis), .periph_events_zero_i(ev_z), .periph_events_one_i(ev_o),
    .ext_pin_i(pins), .pending_zero_o(pend_z), .pending_one_o(pend_o),
    .alt_vector_select_o(alt));
  ifcr_partner i_part (.clk_sys_i(clk_sys_i), .ev_zero_o(ev_z), .ev_one_o(ev_o),
    .stack_o(stk), .osc_o(osc), .disable_o(dis), .pin_o(pins));
  ////////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes launched right after an edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // everything clear after reset, unmapped index included
  task automatic t_reset;
    for (int a = 0; a < 7; a++) rd(a[3:0], 16'h0000);
  endtask
  // control registers: read-only and unimplemented bits, traps
  task automatic t_control;
    wr(IFCR_ADDR_CTRL_TWO, 16'hffff);
    rd(IFCR_ADDR_CTRL_TWO, 16'h8007);
    `CHK(alt, 1'b1)
    i_part.level(1'b1, 3'h0);
    rd(IFCR_ADDR_CTRL_TWO, 16'hc007);
    i_part.level(1'b0, 3'h0);
    wr(IFCR_ADDR_CTRL_TWO, 16'h0000);
    rd(IFCR_ADDR_CTRL_TWO, 16'h0000);
    `CHK(alt, 1'b0)
    wr(IFCR_ADDR_CTRL_ONE, 16'h0001);
    rd(IFCR_ADDR_CTRL_ONE, 16'h0000);
    i_part.pulse(16'h0000, 16'h0000, 1'b1, 1'b0);
    rd(IFCR_ADDR_CTRL_ONE, 16'h0004);
    i_part.pulse(16'h0000, 16'h0000, 1'b0, 1'b1);
    rd(IFCR_ADDR_CTRL_ONE, 16'h0006);
    wr(IFCR_ADDR_CTRL_ONE, 16'h0000);
    rd(IFCR_ADDR_CTRL_ONE, 16'h0000);
  endtask
  // flag layout, enable gating, software clear against a new event
  task automatic t_flags;
    i_part.pulse(16'hffff, 16'hffff, 1'b0, 1'b0);
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h7fef);
    rd(IFCR_ADDR_FLAGS_ONE, 16'he87f);
    wr(IFCR_ADDR_ENABLE_ZERO, 16'h0801);
    wr(IFCR_ADDR_ENABLE_ONE, 16'h8000);
    #1;
    `CHK(pend_z, 16'h0801)
    `CHK(pend_o, 16'h8000)
    fork
      wr(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
      i_part.pulse(16'h0008, 16'h0000, 1'b0, 1'b0);
    join
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0008);
    wr(IFCR_ADDR_FLAGS_ONE, 16'h0040);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0040);
    #1;
    `CHK(pend_o, 16'h0000)
    wr(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    wr(IFCR_ADDR_FLAGS_ONE, 16'h0000);
  endtask
  // pin edges of both polarities, static levels give nothing
  task automatic t_ext;
    wr(IFCR_ADDR_CTRL_TWO, 16'h0007);
    i_part.level(1'b0, 3'h7);
    repeat (6) @(posedge clk_sys_i);
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0000);
    i_part.level(1'b0, 3'h0);
    repeat (6) @(posedge clk_sys_i);
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0001);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0003);
    wr(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    wr(IFCR_ADDR_FLAGS_ONE, 16'h0000);
    wr(IFCR_ADDR_CTRL_TWO, 16'h0000);
    repeat (6) @(posedge clk_sys_i);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0000);
    i_part.level(1'b0, 3'h7);
    repeat (6) @(posedge clk_sys_i);
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0001);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0003);
    `CHK(pend_z, 16'h0001)
  endtask
  // clock enable low freezes flags, traps and read data
  task automatic t_freeze;
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    i_part.pulse(16'h0004, 16'h0000, 1'b1, 1'b0);
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    rd(IFCR_ADDR_CTRL_ONE, 16'h0000);
  endtask
  // reset in mid-run with pins held high: all clear, no false edge
  task automatic t_rerun;
    wr(IFCR_ADDR_CTRL_TWO, 16'h8005);
    i_part.pulse(16'h0002, 16'h0800, 1'b1, 1'b1);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    `CHK(alt, 1'b0)
    wr(4'h6, 16'hffff);
    t_reset;
    rd(IFCR_ADDR_FLAGS_ZERO, 16'h0000);
    rd(IFCR_ADDR_FLAGS_ONE, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // 50 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, far beyond the roughly 170 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    complete_run;
  end
  // main sequence
  initial begin
    err_total   = 0;
    checks_done = 0;
    rstn_i      = 1'b0;
    clk_en_i    = 1'b1;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset;
    t_control;
    t_flags;
    t_freeze;
    t_ext;
    t_rerun;
    complete_run;
  end
endmodule
